// File: tb/charger_fault_event_flags_tb.sv
// Self-checking bench for the fault and event flag registers
// Assumes chfef_flags and the host model chfef_host are compiled before it
`timescale 1ns/1ps
module charger_fault_event_flags_tb;
  import chfef_pkg::*;
  typedef struct {logic [18:0] c; logic [7:0] f1; logic [7:0] f2;} chfef_row_t;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_rst = 1'b0;
  logic        wdt_expire = 1'b0;
  chfef_cond_t cond = '0;
  chfef_req_t  req;
  logic [7:0]  rd_data_q;
  logic [7:0]  q;
  logic        irq_q;
  int          fail_count = 0;
  int          tests_run = 0;
  chfef_row_t  rows [19] = '{
    '{19'h40000, 8'h80, 8'h00}, '{19'h20000, 8'h40, 8'h00}, '{19'h10000, 8'h20, 8'h00},
    '{19'h08000, 8'h10, 8'h00}, '{19'h04000, 8'h08, 8'h00}, '{19'h03000, 8'h04, 8'h00},
    '{19'h02000, 8'h00, 8'h00}, '{19'h00C00, 8'h02, 8'h00}, '{19'h00800, 8'h00, 8'h00},
    '{19'h00200, 8'h01, 8'h00}, '{19'h00180, 8'h00, 8'h40}, '{19'h00100, 8'h00, 8'h00},
    '{19'h00020, 8'h00, 8'h20}, '{19'h00010, 8'h00, 8'h10}, '{19'h00002, 8'h00, 8'h02},
    '{19'h00001, 8'h00, 8'h01}, '{19'h00048, 8'h00, 8'h08}, '{19'h00044, 8'h00, 8'h04},
    '{19'h00008, 8'h00, 8'h00}};

  always #2.5 clk_sys = ~clk_sys;

  chfef_flags DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_rst(reg_rst), .wdt_expire(wdt_expire),
                   .cond(cond), .req(req), .rd_data_q(rd_data_q), .irq_q(irq_q));
  chfef_host host (.clk_sys(clk_sys), .req(req), .rd_data_q(rd_data_q));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask

  // One-cycle condition; the flag and interrupt show on the edge that samples it
  task automatic pulse(input logic [18:0] c);
    cond = chfef_cond_t'(c);
    @(posedge clk_sys);
    #1;
    cond = '0;
  endtask

  task automatic end_sim;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rd(REG_MASK2_OFS, MASK_RESET);
    rd(REG_FLAGS1_OFS, FLAGS_RESET);
    for (int i = 0; i < 19; i++) begin
      pulse(rows[i].c);
      chk({7'h00, irq_q}, {7'h00, |{rows[i].f1, rows[i].f2}});
      rd(REG_FLAGS1_OFS, rows[i].f1);
      rd(REG_FLAGS2_OFS, rows[i].f2);
      chk({7'h00, irq_q}, 8'h00);
    end
    // Masks, reserved bit, ignored write, unmapped read
    wr(REG_MASK1_OFS, 8'hFF);
    wr(REG_MASK2_OFS, 8'hFF);
    rd(REG_MASK1_OFS, 8'hFF);
    rd(REG_MASK2_OFS, 8'h7F);
    pulse(19'h40002);
    chk({7'h00, irq_q}, 8'h00);
    wr(REG_FLAGS1_OFS, 8'h00);
    rd(8'h05, 8'h00);
    rd(REG_FLAGS1_OFS, 8'h80);
    // Register-reset command clears flags and masks; watchdog expiry clears flags
    reg_rst = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rst = 1'b0;
    rd(REG_FLAGS2_OFS, 8'h00);
    rd(REG_MASK1_OFS, 8'h00);
    rd(REG_MASK2_OFS, 8'h00);
    pulse(19'h40000);
    wdt_expire = 1'b1;
    @(posedge clk_sys);
    #1;
    wdt_expire = 1'b0;
    rd(REG_FLAGS1_OFS, 8'h00);
    // Event held across a clearing read
    cond.input_overvoltage = 1'b1;
    cond.die_overheat = 1'b1;
    rd(REG_FLAGS1_OFS, 8'h80);
    rd(REG_FLAGS2_OFS, 8'h02);
    rd(REG_FLAGS1_OFS, 8'h80);
    cond = '0;
    rd(REG_FLAGS1_OFS, 8'h80);
    rd(REG_FLAGS2_OFS, 8'h02);
    rd(REG_FLAGS1_OFS, 8'h00);
    rd(REG_FLAGS2_OFS, 8'h00);
    // Supply crossing both ways while enabled, no re-set on a held level
    cond = chfef_cond_t'(19'h00048);
    rd(REG_FLAGS2_OFS, 8'h08);
    rd(REG_FLAGS2_OFS, 8'h00);
    cond = chfef_cond_t'(19'h00040);
    rd(REG_FLAGS2_OFS, 8'h08);
    cond = '0;
    // Hard reset in mid-run
    pulse(19'h00001);
    rst_n = 1'b0;
    #1;
    chk({7'h00, irq_q}, 8'h00);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rd(REG_FLAGS2_OFS, 8'h00);
    end_sim();
  end
endmodule

// File: tb/chfef_host.sv
// Host processor model that reaches the flag registers through the bridge strobes
// Assumes the bridge takes a request and answers on the same rising edge
`timescale 1ns/1ps
module chfef_host
  import chfef_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Register access
  output chfef_req_t      req,
  input  wire logic [7:0] rd_data_q
);
  initial req = '0;

  // One transfer; released address and data show their inverse, not a stale value
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    req = '{rd_en: !wr, wr_en: wr, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    q = rd_data_q;
    req = '{rd_en: 1'b0, wr_en: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// File: verilog/chfef_flags.sv
// Fault and event flag registers with masks and host interrupt
// Operation
// - All flags clear on reset low, register-reset command, or watchdog expiry.
// - Bit 7 of register 03h latches input over-voltage; reading clears flags.
// - Bit 6 of 03h sets while input current loop regulates.
// - Bit 5 of 03h sets while cell voltage loop regulates.
// - Bit 4 of 03h sets while battery current loop regulates.
// - Bit 3 of 03h sets while output voltage loop regulates.
// - Bit 2 of 03h sets on input thermistor hot, channel active only.
// - Bit 1 of 03h sets on battery thermistor hot, channel active only.
// - Bit 0 of 03h sets on reverse current above threshold.
// - Bit 7 of 04h is reserved and reads 0.
// - Bit 6 of 04h sets on conversion done, one-shot mode only.
// - Bit 3 of 04h sets on either supply UVLO crossing while converter enabled.
// - Bit 2 of 04h sets on either cell insert crossing while converter enabled.
// - Bit 1 of 04h sets on die over-temperature.
// - Bits 5 and 4 of 04h flag drop alarm and drop over-voltage.
// - Bit 0 of 04h flags input over-current.
// - Each flag has a same-position mask bit; masks clear on the same resets as flags, not on reading.
// Assumes condition inputs are synchronous to clk_sys and bus strobes are one-cycle pulses
`timescale 1ns/1ps
module chfef_flags
  import chfef_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Soft reset sources
  input  wire logic              reg_rst,
  input  wire logic              wdt_expire,
  // Event conditions
  input  wire chfef_cond_t       cond,
  // Register access
  input  wire chfef_req_t        req,
  output logic [DATA_W-1:0]      rd_data_q,
  // Host interrupt
  output logic                   irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Event detection

  logic [7:0] ev1;
  logic [7:0] ev2;
  logic       uvlo_prev_q;
  logic       uvlo_prev_d;
  logic       ins_prev_q;
  logic       ins_prev_d;

  always_comb begin
    ev1                = 8'h00;
    ev2                = 8'h00;
    ev1[F1_INPUT_OV]   = cond.input_overvoltage;
    ev1[F1_INPUT_CUR]  = cond.input_current_regulating;
    ev1[F1_CELL_VOLT]  = cond.cell_voltage_regulating;
    ev1[F1_BATT_CUR]   = cond.battery_current_regulating;
    ev1[F1_OUT_VOLT]   = cond.output_voltage_regulating;
    ev1[F1_IN_THERM]   = cond.input_thermistor_hot & cond.input_thermistor_channel;
    ev1[F1_BATT_THERM] = cond.battery_thermistor_hot & cond.battery_thermistor_channel;
    ev1[F1_REVERSE]    = cond.reverse_current;
    ev2[F2_CONV_DONE]  = cond.conversion_done & cond.one_shot_mode;
    ev2[F2_DROP_ALARM] = cond.drop_alarm;
    ev2[F2_DROP_OV]    = cond.drop_overvoltage;
    ev2[F2_SUPPLY_ATT] = cond.converter_enabled & (cond.supply_above_uvlo ^ uvlo_prev_q);
    ev2[F2_CELL_ATT]   = cond.converter_enabled & (cond.cell_above_insert ^ ins_prev_q);
    ev2[F2_DIE_HOT]    = cond.die_overheat;
    ev2[F2_INPUT_OC]   = cond.input_overcurrent;
    uvlo_prev_d        = cond.supply_above_uvlo;
    ins_prev_d         = cond.cell_above_insert;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      uvlo_prev_q <= 1'b0;
      ins_prev_q  <= 1'b0;
    end else begin
      uvlo_prev_q <= uvlo_prev_d;
      ins_prev_q  <= ins_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, masks, read port and interrupt

  logic [7:0] flags1_q;
  logic [7:0] flags1_d;
  logic [7:0] flags2_q;
  logic [7:0] flags2_d;
  logic [7:0] mask1_q;
  logic [7:0] mask1_d;
  logic [7:0] mask2_q;
  logic [7:0] mask2_d;
  logic [7:0] rd_data_d;
  logic       irq_d;
  logic       soft_rst;

  always_comb begin
    soft_rst  = reg_rst | wdt_expire;
    flags1_d  = flags1_q;
    flags2_d  = flags2_q;
    mask1_d   = mask1_q;
    mask2_d   = mask2_q;
    rd_data_d = rd_data_q;
    if (req.rd_en) begin
      case (req.addr)
        REG_MASK1_OFS:  rd_data_d = mask1_q;
        REG_MASK2_OFS:  rd_data_d = mask2_q;
        REG_FLAGS1_OFS: rd_data_d = flags1_q;
        REG_FLAGS2_OFS: rd_data_d = flags2_q;
        default:        rd_data_d = 8'h00;
      endcase
      if (req.addr == REG_FLAGS1_OFS) begin
        flags1_d = FLAGS_RESET;
      end
      if (req.addr == REG_FLAGS2_OFS) begin
        flags2_d = FLAGS_RESET;
      end
    end
    if (req.wr_en && req.addr == REG_MASK1_OFS) begin
      mask1_d = req.wdata;
    end
    if (req.wr_en && req.addr == REG_MASK2_OFS) begin
      mask2_d = req.wdata & MASK2_WMASK;
    end
    flags1_d = flags1_d | ev1;
    flags2_d = (flags2_d | ev2) & MASK2_WMASK;
    if (soft_rst) begin
      flags1_d = FLAGS_RESET;
      flags2_d = FLAGS_RESET;
      mask1_d  = MASK_RESET;
      mask2_d  = MASK_RESET;
    end
    irq_d = |((flags1_d & ~mask1_d) | (flags2_d & ~mask2_d));
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags1_q  <= FLAGS_RESET;
      flags2_q  <= FLAGS_RESET;
      mask1_q   <= MASK_RESET;
      mask2_q   <= MASK_RESET;
      rd_data_q <= 8'h00;
      irq_q     <= 1'b0;
    end else begin
      flags1_q  <= flags1_d;
      flags2_q  <= flags2_d;
      mask1_q   <= mask1_d;
      mask2_q   <= mask2_d;
      rd_data_q <= rd_data_d;
      irq_q     <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_soft_reset_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rst || wdt_expire) |=> (flags1_q == 8'h00 && flags2_q == 8'h00 && mask1_q == 8'h00))
    else $error("flags not cleared by soft reset");

  a_ov_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cond.input_overvoltage && !reg_rst && !wdt_expire) ##1
    (!reg_rst && !wdt_expire && !(req.rd_en && req.addr == REG_FLAGS1_OFS))
    |=> flags1_q[F1_INPUT_OV])
    else $error("over-voltage flag lost before read");

  a_read_clears_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd_en && req.addr == REG_FLAGS1_OFS && ev1 == 8'h00)
    |=> (flags1_q == 8'h00 && rd_data_q == $past(flags1_q)))
    else $error("read of first flag register did not clear it");

  a_therm_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(flags1_q[F1_IN_THERM])) |-> $past(cond.input_thermistor_channel))
    else $error("input thermistor flag set with channel off");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !flags2_q[F2_RESERVED] && !mask2_q[F2_RESERVED])
    else $error("reserved bit set");

  a_done_oneshot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cond.conversion_done && !cond.one_shot_mode && !flags2_q[F2_CONV_DONE])
    |=> !flags2_q[F2_CONV_DONE])
    else $error("conversion flag set outside one-shot mode");

  a_supply_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cond.converter_enabled && $changed(cond.supply_above_uvlo) && !reg_rst && !wdt_expire)
    |=> flags2_q[F2_SUPPLY_ATT])
    else $error("supply crossing not flagged");

  a_irq_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_q == |((flags1_q & ~mask1_q) | (flags2_q & ~mask2_q)))
    else $error("interrupt disagrees with unmasked flags");

  a_event_on_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd_en && req.addr == REG_FLAGS2_OFS && cond.die_overheat && !reg_rst && !wdt_expire)
    |=> flags2_q[F2_DIE_HOT])
    else $error("event lost during clearing read");

  a_mask2_soft_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rst || wdt_expire) |=> (mask2_q == 8'h00))
    else $error("second mask not cleared by soft reset");

  a_cell_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cond.converter_enabled && $changed(cond.cell_above_insert) && !reg_rst && !wdt_expire)
    |=> flags2_q[F2_CELL_ATT])
    else $error("cell crossing not flagged");

  a_batt_therm_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(flags1_q[F1_BATT_THERM])) |-> $past(cond.battery_thermistor_channel))
    else $error("battery thermistor flag set with channel off");

  a_read_clears_second: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd_en && req.addr == REG_FLAGS2_OFS && ev2 == 8'h00)
    |=> (flags2_q == 8'h00 && rd_data_q == $past(flags2_q)))
    else $error("read of second flag register did not clear it");

  a_die_hot_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cond.die_overheat && !reg_rst && !wdt_expire)
    |=> flags2_q[F2_DIE_HOT])
    else $error("die over-temperature not flagged");

endmodule

// File: verilog/chfef_pkg.sv
// Package for the charger fault and event flag block
// Assumes a host-side serial bridge turns bus transfers into the simple register strobes used here
package chfef_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;

  // Register offsets
  localparam logic [7:0] REG_MASK1_OFS = 8'h01;
  localparam logic [7:0] REG_MASK2_OFS = 8'h02;
  localparam logic [7:0] REG_FLAGS1_OFS = 8'h03;
  localparam logic [7:0] REG_FLAGS2_OFS = 8'h04;

  // Reset values and reserved-bit write mask
  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] MASK2_WMASK  = 8'h7F;

  // Field positions, first flag register
  localparam int unsigned F1_INPUT_OV     = 7;
  localparam int unsigned F1_INPUT_CUR    = 6;
  localparam int unsigned F1_CELL_VOLT    = 5;
  localparam int unsigned F1_BATT_CUR     = 4;
  localparam int unsigned F1_OUT_VOLT     = 3;
  localparam int unsigned F1_IN_THERM     = 2;
  localparam int unsigned F1_BATT_THERM   = 1;
  localparam int unsigned F1_REVERSE      = 0;

  // Field positions, second flag register
  localparam int unsigned F2_RESERVED     = 7;
  localparam int unsigned F2_CONV_DONE    = 6;
  localparam int unsigned F2_DROP_ALARM   = 5;
  localparam int unsigned F2_DROP_OV      = 4;
  localparam int unsigned F2_SUPPLY_ATT   = 3;
  localparam int unsigned F2_CELL_ATT     = 2;
  localparam int unsigned F2_DIE_HOT      = 1;
  localparam int unsigned F2_INPUT_OC     = 0;

  // Condition inputs from the analog comparators and converter
  typedef struct packed {
    logic input_overvoltage;
    logic input_current_regulating;
    logic cell_voltage_regulating;
    logic battery_current_regulating;
    logic output_voltage_regulating;
    logic input_thermistor_hot;
    logic input_thermistor_channel;
    logic battery_thermistor_hot;
    logic battery_thermistor_channel;
    logic reverse_current;
    logic conversion_done;
    logic one_shot_mode;
    logic converter_enabled;
    logic drop_alarm;
    logic drop_overvoltage;
    logic supply_above_uvlo;
    logic cell_above_insert;
    logic die_overheat;
    logic input_overcurrent;
  } chfef_cond_t;

  // Register access strobes from the serial bridge
  typedef struct packed {
    logic       rd_en;
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chfef_req_t;

endpackage
